// ### src/peripheral_io_register_map.sv
`timescale 1ns/1ps
module peripheral_io_register_map #(
   parameter bit DISP_ON_PAGE2 = 1'b0
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_arst_n,
   input  wire pio_map_pkg::cpu_req_t     i_req,
   output logic [3:0]                     o_rdata,
   output logic                           o_rvalid,
   output logic                           o_disp_wr,
   output logic [5:0]                     o_disp_index,
   output logic [3:0]                     o_disp_wdata,
   input  wire pio_map_pkg::periph_stat_t i_stat,
   input  wire pio_map_pkg::periph_ev_t   i_ev,
   output pio_map_pkg::periph_ctrl_t      o_ctrl,
   output logic [3:0]                     o_irq_pending,
   input  wire logic [3:0]                i_input_group_a,
   input  wire logic                      i_single_input,
   input  wire logic [3:0]                i_input_group_c,
   input  wire logic [3:0]                i_bidir_port_a_pin,
   output logic [3:0]                     o_bidir_port_a_pin,
   output logic [3:0]                     o_bidir_port_a_pin_oe
);
   import pio_map_pkg::*;

   logic [3:0]   in_a_s1_ff, in_a_s2_ff, in_a_s3_ff, in_a_ff;
   logic [3:0]   in_c_s1_ff, in_c_s2_ff, in_c_s3_ff, in_c_ff;
   logic [3:0]   pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff;
   logic         in_s_s1_ff, in_s_s2_ff, in_s_s3_ff, in_s_ff;
   logic [3:0]   disp_mem_ff [DISP_WORDS];
   logic [3:0]   bidir_latch_ff;
   logic [2:0]   tmr_flag_ff;
   logic [3:0]   in_sw_flag_ff;
   logic [1:0]   ser_in_flag_ff;
   periph_ctrl_t ctrl_ff;
   logic [3:0]   nxt_rdata;
   logic         wr, rd;
   logic         disp_hit;
   logic [5:0]   disp_idx;

   assign wr = i_req.wr;
   assign rd = i_req.rd;

   // window test shared by reads and writes
   function automatic logic in_disp(input logic [9:0] a);
      if (DISP_ON_PAGE2)
         in_disp = (a >= ADDR_DISP_P2_LO) && (a <= ADDR_DISP_P2_HI);
      else
         in_disp = (a >= ADDR_DISP_P0_LO) && (a <= ADDR_DISP_P0_HI);
   endfunction

   function automatic logic [5:0] disp_offset(input logic [9:0] a);
      logic [9:0] base;
      base = DISP_ON_PAGE2 ? ADDR_DISP_P2_LO : ADDR_DISP_P0_LO;
      disp_offset = 6'(a - base);
   endfunction

   assign disp_hit = in_disp(i_req.addr);
   assign disp_idx = disp_offset(i_req.addr);

   // pin inputs: change accepted once stages two and three agree
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         in_a_s1_ff <= RST_ZERO;
         in_a_s2_ff <= RST_ZERO;
         in_a_s3_ff <= RST_ZERO;
         in_a_ff    <= RST_ZERO;
         in_c_s1_ff <= RST_ZERO;
         in_c_s2_ff <= RST_ZERO;
         in_c_s3_ff <= RST_ZERO;
         in_c_ff    <= RST_ZERO;
         pin_s1_ff  <= RST_ZERO;
         pin_s2_ff  <= RST_ZERO;
         pin_s3_ff  <= RST_ZERO;
         pin_ff     <= RST_ZERO;
         in_s_s1_ff <= 1'b0;
         in_s_s2_ff <= 1'b0;
         in_s_s3_ff <= 1'b0;
         in_s_ff    <= 1'b0;
      end else begin
         in_a_s1_ff <= i_input_group_a;
         in_a_s2_ff <= in_a_s1_ff;
         in_a_s3_ff <= in_a_s2_ff;
         in_c_s1_ff <= i_input_group_c;
         in_c_s2_ff <= in_c_s1_ff;
         in_c_s3_ff <= in_c_s2_ff;
         pin_s1_ff  <= i_bidir_port_a_pin;
         pin_s2_ff  <= pin_s1_ff;
         pin_s3_ff  <= pin_s2_ff;
         in_s_s1_ff <= i_single_input;
         in_s_s2_ff <= in_s_s1_ff;
         in_s_s3_ff <= in_s_s2_ff;
         for (int b = 0; b < 4; b++) begin
            if (in_a_s2_ff[b] == in_a_s3_ff[b])
               in_a_ff[b] <= in_a_s3_ff[b];
            if (in_c_s2_ff[b] == in_c_s3_ff[b])
               in_c_ff[b] <= in_c_s3_ff[b];
            if (pin_s2_ff[b] == pin_s3_ff[b])
               pin_ff[b] <= pin_s3_ff[b];
         end
         if (in_s_s2_ff == in_s_s3_ff)
            in_s_ff <= in_s_s3_ff;
      end
   end

   // display memory: no reset, contents undefined until written
   always_ff @(posedge i_clk) begin
      if (wr && disp_hit)
         disp_mem_ff[disp_idx] <= i_req.wdata;
   end

   // control registers; writes to read-only bits fall through untouched
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_ff               <= '0;
         ctrl_ff.display_blank <= RST_DISPLAY_BLANK[0];
         ctrl_ff.serial_clock_select <= RST_SER_CLK_SEL;
         bidir_latch_ff        <= RST_ZERO;
      end else begin
         // trigger bits live for one cycle only
         ctrl_ff.clock_timer_clear    <= 1'b0;
         ctrl_ff.stopwatch_clear      <= 1'b0;
         ctrl_ff.watchdog_clear       <= 1'b0;
         ctrl_ff.serial_clock_trigger <= 1'b0;
         ctrl_ff.envelope_clear       <= 1'b0;
         if (i_stat.serial_shift_load)
            ctrl_ff.serial_shift_bit <= i_stat.serial_shift_in;
         if (wr) begin
            unique case (i_req.addr)
               ADDR_DISPLAY_BLANK: ctrl_ff.display_blank <= i_req.wdata[0];
               ADDR_IN_A_CMP:      ctrl_ff.input_group_a_cmp <= i_req.wdata;
               ADDR_IN_A_MASK:     ctrl_ff.input_group_a_irq_en <= i_req.wdata;
               ADDR_LOAD_BATT_SW: begin
                  ctrl_ff.heavy_load_protect   <= i_req.wdata[BIT_HEAVY_LOAD];
                  ctrl_ff.stopwatch_irq_enable <= i_req.wdata[1:0];
               end
               ADDR_SER_TRG_IN: begin
                  ctrl_ff.serial_clock_trigger <= i_req.wdata[3];
                  ctrl_ff.single_input_irq_en  <= i_req.wdata[2];
                  ctrl_ff.single_input_cmp     <= i_req.wdata[1];
               end
               ADDR_LCD_TMR_MASK: begin
                  ctrl_ff.lcd_static_dynamic_select <= i_req.wdata[3];
                  ctrl_ff.clock_timer_irq_enable    <= i_req.wdata[2:0];
               end
               ADDR_OUT_A: ctrl_ff.output_port_a_bit <= i_req.wdata;
               ADDR_OUT_B: begin
                  ctrl_ff.output_port_b_bit[3:2] <= i_req.wdata[3:2];
                  ctrl_ff.output_port_b_bit[0]   <= i_req.wdata[0];
               end
               ADDR_BIDIR_A: bidir_latch_ff <= i_req.wdata;
               ADDR_TMR_CTRL_DIR: begin
                  ctrl_ff.clock_timer_clear <= i_req.wdata[3];
                  ctrl_ff.stopwatch_run     <= i_req.wdata[BIT_SW_RUN];
                  ctrl_ff.stopwatch_clear   <= i_req.wdata[1];
                  ctrl_ff.port_a_direction  <= i_req.wdata[BIT_PORT_DIR];
               end
               ADDR_WDOG: ctrl_ff.watchdog_clear <= i_req.wdata[3];
               ADDR_SER_LOW:  ctrl_ff.serial_shift_bit[3:0] <= i_req.wdata;
               ADDR_SER_HIGH: ctrl_ff.serial_shift_bit[7:4] <= i_req.wdata;
               ADDR_SER_CFG: begin
                  ctrl_ff.serial_clock_select <= i_req.wdata[3:2];
                  ctrl_ff.serial_edge_select  <= i_req.wdata[BIT_SER_EDGE];
                  ctrl_ff.serial_irq_enable   <= i_req.wdata[BIT_SER_IRQ_EN];
               end
               ADDR_IN_C_MASK: ctrl_ff.input_group_c_irq_en <= i_req.wdata;
               ADDR_BUZZ_ENV: begin
                  ctrl_ff.buzzer_pitch_select <= i_req.wdata[3:1];
                  ctrl_ff.envelope_clear      <= i_req.wdata[0];
               end
               ADDR_ENV_CMP: begin
                  ctrl_ff.envelope_enable        <= i_req.wdata[BIT_ENV_EN];
                  ctrl_ff.envelope_period_select <= i_req.wdata[BIT_ENV_PERIOD];
                  ctrl_ff.comparator_enable      <= i_req.wdata[BIT_CMP_EN];
               end
               default: ;
            endcase
         end
      end
   end

   // factor flags: a same-cycle event beats the read clear
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tmr_flag_ff    <= 3'h0;
         in_sw_flag_ff  <= RST_ZERO;
         ser_in_flag_ff <= 2'h0;
      end else begin
         tmr_flag_ff <= ((rd && i_req.addr == ADDR_TMR_FLAGS) ? 3'h0 : tmr_flag_ff)
                        | i_ev.timer_ev;
         in_sw_flag_ff <= ((rd && i_req.addr == ADDR_IN_SW_FLAGS) ? 4'h0 : in_sw_flag_ff)
                          | {i_ev.single_input_ev, i_ev.input_group_a_ev,
                             i_ev.stopwatch_ev};
         ser_in_flag_ff <= ((rd && i_req.addr == ADDR_SER_IN_FLAGS) ? 2'h0 : ser_in_flag_ff)
                           | {i_ev.input_group_c_ev, i_ev.serial_done_ev};
      end
   end

   // read mux; unmapped and write-only bits read 0
   always_comb begin
      nxt_rdata = 4'h0;
      if (disp_hit && !DISP_ON_PAGE2)
         nxt_rdata = disp_mem_ff[disp_idx];
      unique case (i_req.addr)
         ADDR_DISPLAY_BLANK: nxt_rdata = {3'h0, ctrl_ff.display_blank};
         ADDR_CLOCK_TIMER:   nxt_rdata = i_stat.clock_timer_stage;
         ADDR_SW_HUND:       nxt_rdata = i_stat.stopwatch_hundredths_digit;
         ADDR_SW_TENTH:      nxt_rdata = i_stat.stopwatch_tenths_digit;
         ADDR_IN_A_LEVEL:    nxt_rdata = in_a_ff;
         ADDR_IN_A_CMP:      nxt_rdata = ctrl_ff.input_group_a_cmp;
         ADDR_IN_A_MASK:     nxt_rdata = ctrl_ff.input_group_a_irq_en;
         ADDR_LOAD_BATT_SW:  nxt_rdata = {ctrl_ff.heavy_load_protect,
                                          i_stat.sub_lowbatt_result,
                                          ctrl_ff.stopwatch_irq_enable};
         ADDR_SER_TRG_IN:    nxt_rdata = {1'b0, ctrl_ff.single_input_irq_en,
                                          ctrl_ff.single_input_cmp, in_s_ff};
         ADDR_LCD_TMR_MASK:  nxt_rdata = {ctrl_ff.lcd_static_dynamic_select,
                                          ctrl_ff.clock_timer_irq_enable};
         ADDR_TMR_FLAGS:     nxt_rdata = {1'b0, tmr_flag_ff};
         ADDR_IN_SW_FLAGS:   nxt_rdata = in_sw_flag_ff;
         ADDR_OUT_A:         nxt_rdata = ctrl_ff.output_port_a_bit;
         ADDR_OUT_B:         nxt_rdata = {ctrl_ff.output_port_b_bit[3:2],
                                          i_stat.serial_run_status,
                                          ctrl_ff.output_port_b_bit[0]};
         ADDR_BIDIR_A:       nxt_rdata = pin_ff;
         ADDR_TMR_CTRL_DIR:  nxt_rdata = {1'b0, ctrl_ff.stopwatch_run, 1'b0,
                                          ctrl_ff.port_a_direction};
         ADDR_WDOG:          nxt_rdata = {1'b0, i_stat.watchdog_stage};
         ADDR_SER_LOW:       nxt_rdata = ctrl_ff.serial_shift_bit[3:0];
         ADDR_SER_HIGH:      nxt_rdata = ctrl_ff.serial_shift_bit[7:4];
         ADDR_SER_CFG:       nxt_rdata = {ctrl_ff.serial_clock_select,
                                          ctrl_ff.serial_edge_select,
                                          ctrl_ff.serial_irq_enable};
         ADDR_SER_IN_FLAGS:  nxt_rdata = {2'h0, ser_in_flag_ff};
         ADDR_IN_C_LEVEL:    nxt_rdata = in_c_ff;
         ADDR_IN_C_MASK:     nxt_rdata = ctrl_ff.input_group_c_irq_en;
         ADDR_BUZZ_ENV:      nxt_rdata = {ctrl_ff.buzzer_pitch_select, 1'b0};
         ADDR_ENV_CMP:       nxt_rdata = {ctrl_ff.envelope_enable,
                                          ctrl_ff.envelope_period_select,
                                          i_stat.comparator_result,
                                          ctrl_ff.comparator_enable};
         ADDR_EV0_LOW:       nxt_rdata = i_stat.event_count_zero[3:0];
         ADDR_EV0_HIGH:      nxt_rdata = i_stat.event_count_zero[7:4];
         ADDR_EV1_LOW:       nxt_rdata = i_stat.event_count_one[3:0];
         ADDR_EV1_HIGH:      nxt_rdata = i_stat.event_count_one[7:4];
         default: ;
      endcase
   end

   // registered outputs
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata               <= RST_ZERO;
         o_rvalid              <= 1'b0;
         o_disp_wr             <= 1'b0;
         o_disp_index          <= 6'h0;
         o_disp_wdata          <= RST_ZERO;
         o_ctrl                <= '0;
         o_ctrl.display_blank  <= RST_DISPLAY_BLANK[0];
         o_ctrl.serial_clock_select <= RST_SER_CLK_SEL;
         o_irq_pending         <= RST_ZERO;
         o_bidir_port_a_pin    <= RST_ZERO;
         o_bidir_port_a_pin_oe <= RST_ZERO;
      end else begin
         o_rdata               <= rd ? nxt_rdata : 4'h0;
         o_rvalid              <= rd;
         o_disp_wr             <= wr && disp_hit;
         o_disp_index          <= disp_idx;
         o_disp_wdata          <= i_req.wdata;
         o_ctrl                <= ctrl_ff;
         o_irq_pending[0]      <= |(tmr_flag_ff & ctrl_ff.clock_timer_irq_enable);
         o_irq_pending[1]      <= |(in_sw_flag_ff[1:0] & ctrl_ff.stopwatch_irq_enable)
                                  | in_sw_flag_ff[3] & ctrl_ff.single_input_irq_en
                                  | in_sw_flag_ff[2] & (|ctrl_ff.input_group_a_irq_en);
         o_irq_pending[2]      <= ser_in_flag_ff[1] & (|ctrl_ff.input_group_c_irq_en);
         o_irq_pending[3]      <= ser_in_flag_ff[0] & ctrl_ff.serial_irq_enable;
         o_bidir_port_a_pin    <= bidir_latch_ff;
         o_bidir_port_a_pin_oe <= {4{ctrl_ff.port_a_direction}};
      end
   end
endmodule

// ### src/pio_map_pkg.sv
package pio_map_pkg;
   localparam logic [9:0] ADDR_DISPLAY_BLANK = 10'h2d0;
   localparam logic [9:0] ADDR_CLOCK_TIMER   = 10'h2e0;
   localparam logic [9:0] ADDR_SW_HUND       = 10'h2e1;
   localparam logic [9:0] ADDR_SW_TENTH      = 10'h2e2;
   localparam logic [9:0] ADDR_IN_A_LEVEL    = 10'h2e3;
   localparam logic [9:0] ADDR_IN_A_CMP      = 10'h2e4;
   localparam logic [9:0] ADDR_IN_A_MASK     = 10'h2e5;
   localparam logic [9:0] ADDR_LOAD_BATT_SW  = 10'h2e6;
   localparam logic [9:0] ADDR_SER_TRG_IN    = 10'h2e7;
   localparam logic [9:0] ADDR_LCD_TMR_MASK  = 10'h2e8;
   localparam logic [9:0] ADDR_TMR_FLAGS     = 10'h2e9;
   localparam logic [9:0] ADDR_IN_SW_FLAGS   = 10'h2ea;
   localparam logic [9:0] ADDR_OUT_A         = 10'h2eb;
   localparam logic [9:0] ADDR_OUT_B         = 10'h2ec;
   localparam logic [9:0] ADDR_BIDIR_A       = 10'h2ed;
   localparam logic [9:0] ADDR_TMR_CTRL_DIR  = 10'h2ee;
   localparam logic [9:0] ADDR_WDOG          = 10'h2ef;
   localparam logic [9:0] ADDR_SER_LOW       = 10'h2f0;
   localparam logic [9:0] ADDR_SER_HIGH      = 10'h2f1;
   localparam logic [9:0] ADDR_SER_CFG       = 10'h2f2;
   localparam logic [9:0] ADDR_SER_IN_FLAGS  = 10'h2f3;
   localparam logic [9:0] ADDR_IN_C_LEVEL    = 10'h2f4;
   localparam logic [9:0] ADDR_IN_C_MASK     = 10'h2f5;
   localparam logic [9:0] ADDR_BUZZ_ENV      = 10'h2f6;
   localparam logic [9:0] ADDR_ENV_CMP       = 10'h2f7;
   localparam logic [9:0] ADDR_EV0_LOW       = 10'h2f8;
   localparam logic [9:0] ADDR_EV0_HIGH      = 10'h2f9;
   localparam logic [9:0] ADDR_EV1_LOW       = 10'h2fa;
   localparam logic [9:0] ADDR_EV1_HIGH      = 10'h2fb;
   localparam logic [9:0] ADDR_DISP_P0_LO    = 10'h040;
   localparam logic [9:0] ADDR_DISP_P0_HI    = 10'h06f;
   localparam logic [9:0] ADDR_DISP_P2_LO    = 10'h240;
   localparam logic [9:0] ADDR_DISP_P2_HI    = 10'h26f;
   localparam int         DISP_WORDS         = 48;
   localparam logic [3:0] RST_DISPLAY_BLANK  = 4'h1;
   localparam logic [1:0] RST_SER_CLK_SEL    = 2'h3;
   localparam logic [3:0] RST_ZERO           = 4'h0;
   localparam int         BIT_SER_CLK_SEL    = 2;
   localparam int         BIT_SER_EDGE       = 1;
   localparam int         BIT_SER_IRQ_EN     = 0;
   localparam int         BIT_ENV_EN         = 3;
   localparam int         BIT_ENV_PERIOD     = 2;
   localparam int         BIT_CMP_RESULT     = 1;
   localparam int         BIT_CMP_EN         = 0;
   localparam int         BIT_SW_RUN         = 2;
   localparam int         BIT_PORT_DIR       = 0;
   localparam int         BIT_SER_RUN        = 1;
   localparam int         BIT_HEAVY_LOAD     = 3;
   localparam int         BIT_LOWBATT        = 2;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [9:0] addr;
      logic [3:0] wdata;
   } cpu_req_t;

   // live state of peripherals behind the register map
   typedef struct packed {
      logic [3:0] clock_timer_stage;
      logic [3:0] stopwatch_hundredths_digit;
      logic [3:0] stopwatch_tenths_digit;
      logic [2:0] watchdog_stage;
      logic [7:0] event_count_zero;
      logic [7:0] event_count_one;
      logic       sub_lowbatt_result;
      logic       comparator_result;
      logic       serial_run_status;
      logic [7:0] serial_shift_in;
      logic       serial_shift_load;
   } periph_stat_t;

   // hardware event pulses that set factor flags
   typedef struct packed {
      logic [2:0] timer_ev;
      logic       single_input_ev;
      logic       input_group_a_ev;
      logic [1:0] stopwatch_ev;
      logic       input_group_c_ev;
      logic       serial_done_ev;
   } periph_ev_t;

   // control outputs toward the peripherals
   typedef struct packed {
      logic       display_blank;
      logic [3:0] input_group_a_cmp;
      logic       single_input_cmp;
      logic [3:0] input_group_a_irq_en;
      logic       single_input_irq_en;
      logic [3:0] input_group_c_irq_en;
      logic       heavy_load_protect;
      logic [1:0] stopwatch_irq_enable;
      logic       lcd_static_dynamic_select;
      logic [2:0] clock_timer_irq_enable;
      logic [3:0] output_port_a_bit;
      logic [3:0] output_port_b_bit;
      logic       port_a_direction;
      logic       stopwatch_run;
      logic [7:0] serial_shift_bit;
      logic [1:0] serial_clock_select;
      logic       serial_edge_select;
      logic       serial_irq_enable;
      logic [2:0] buzzer_pitch_select;
      logic       envelope_enable;
      logic       envelope_period_select;
      logic       comparator_enable;
      logic       clock_timer_clear;
      logic       stopwatch_clear;
      logic       watchdog_clear;
      logic       serial_clock_trigger;
      logic       envelope_clear;
   } periph_ctrl_t;
endpackage

// ### verification/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
   input  wire logic             i_clk,
   input  wire logic [3:0]       i_rdata,
   input  wire logic             i_rvalid,
   output pio_map_pkg::cpu_req_t o_req
);
   import pio_map_pkg::*;
   initial o_req = '0;
   // one nibble per two-cycle access; the caller keeps to mapped addresses
   task automatic access(input logic w, input logic [9:0] a, input logic [3:0] d,
                         output logic [3:0] r);
      @(posedge i_clk) #1;
      o_req = '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge i_clk) #1;
      r = i_rvalid ? i_rdata : 4'hx;
      o_req = '0;
   endtask
endmodule

// ### verification/peripheral_io_register_map_properties.sv
`timescale 1ns/1ps
module peripheral_io_register_map_properties #(
   parameter bit DISP_ON_PAGE2 = 1'b0
) (
   input wire logic                       i_clk,
   input wire logic                       i_arst_n,
   input wire pio_map_pkg::cpu_req_t      i_req,
   input wire logic [3:0]                 o_rdata,
   input wire logic                       o_rvalid,
   input wire logic                       o_disp_wr,
   input wire pio_map_pkg::periph_ctrl_t  o_ctrl,
   input wire logic [3:0]                 o_bidir_port_a_pin_oe
);
   import pio_map_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   logic [9:0] base;
   logic       in_disp;
   assign base = DISP_ON_PAGE2 ? ADDR_DISP_P2_LO : ADDR_DISP_P0_LO;
   assign in_disp = i_req.wr && i_req.addr >= base && i_req.addr < base + 10'd48;
   a_read_answered: assert property (i_req.rd |=> o_rvalid)
      else $error("read not answered");
   a_no_stray_answer: assert property (!i_req.rd |=> !o_rvalid && o_rdata == 4'h0)
      else $error("answer without read");
   a_trigger_reads_zero: assert property (i_req.rd && i_req.addr == ADDR_TMR_CTRL_DIR
      |=> o_rdata[3] == 1'b0 && o_rdata[1] == 1'b0)
      else $error("trigger bit read nonzero");
   a_unused_reads_zero: assert property (i_req.rd && i_req.addr == ADDR_DISPLAY_BLANK
      |=> o_rdata[3:1] == 3'h0)
      else $error("unused bits read nonzero");
   a_blank_follows_write: assert property (i_req.wr && i_req.addr == ADDR_DISPLAY_BLANK
      |=> ##1 o_ctrl.display_blank == $past(i_req.wdata[0], 2))
      else $error("blank control not updated");
   a_dir_drives_oe: assert property (i_req.wr && i_req.addr == ADDR_TMR_CTRL_DIR
      |=> ##1 o_bidir_port_a_pin_oe == {4{$past(i_req.wdata[0], 2)}})
      else $error("port enable wrong");
   a_disp_write_pulse: assert property (in_disp |=> o_disp_wr)
      else $error("display write lost");
   a_disp_only_window: assert property (!in_disp |=> !o_disp_wr)
      else $error("stray display write");
   a_wdog_clear_pulse: assert property (i_req.wr && i_req.addr == ADDR_WDOG
      |=> ##1 o_ctrl.watchdog_clear == $past(i_req.wdata[3], 2))
      else $error("watchdog clear pulse wrong");
   a_wdog_clear_ends: assert property (!(i_req.wr && i_req.addr == ADDR_WDOG)
      |=> ##1 !o_ctrl.watchdog_clear)
      else $error("watchdog clear held too long");
   cover property (o_ctrl.watchdog_clear);
   cover property (i_req.rd && i_req.addr == ADDR_TMR_FLAGS ##1 o_rdata != 4'h0);
   cover property (o_disp_wr);
   cover property ($rose(o_ctrl.port_a_direction));
endmodule
bind peripheral_io_register_map peripheral_io_register_map_properties #(
   .DISP_ON_PAGE2(DISP_ON_PAGE2)) i_props (.i_clk, .i_arst_n, .i_req, .o_rdata,
   .o_rvalid, .o_disp_wr, .o_ctrl, .o_bidir_port_a_pin_oe);

// ### verification/peripheral_io_register_map_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end
module peripheral_io_register_map_tb;
   import pio_map_pkg::*;
   logic         i_clk = 1'b0;
   logic         i_arst_n = 1'b0;
   cpu_req_t     req;
   logic [3:0]   rdata, q, pin_out, pin_oe, pin_wire, grp_a, grp_c, disp_data, irq;
   logic         rvalid, disp_wr, single;
   logic [5:0]   disp_idx;
   periph_stat_t stat;
   periph_ev_t   ev;
   periph_ctrl_t ctrl;
   int           n_fail = 0;
   int           cmp_count = 0;
   always #2 i_clk = ~i_clk;
   // far side drives 6 whenever the port is an input
   assign pin_wire = (pin_oe & pin_out) | (~pin_oe & 4'h6);
   cpu_model i_cpu_model (.i_clk, .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
   peripheral_io_register_map i_peripheral_io_register_map (.i_clk, .i_arst_n,
      .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .o_disp_wr(disp_wr),
      .o_disp_index(disp_idx), .o_disp_wdata(disp_data), .i_stat(stat), .i_ev(ev),
      .o_ctrl(ctrl), .o_irq_pending(irq), .i_input_group_a(grp_a), .i_single_input(single),
      .i_input_group_c(grp_c), .i_bidir_port_a_pin(pin_wire), .o_bidir_port_a_pin(pin_out),
      .o_bidir_port_a_pin_oe(pin_oe));
   // second copy with display memory on page 2, on a bus of its own
   if (1) begin : g_page2
      cpu_req_t   req;
      logic [3:0] rdata;
      logic       rvalid, disp_wr;
      logic [5:0] disp_idx;
      cpu_model i_cpu_model (.i_clk, .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
      peripheral_io_register_map #(.DISP_ON_PAGE2(1'b1)) i_peripheral_io_register_map (
         .i_clk, .i_arst_n, .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
         .o_disp_wr(disp_wr), .o_disp_index(disp_idx), .o_disp_wdata(), .i_stat(stat),
         .i_ev(ev), .o_ctrl(), .o_irq_pending(), .i_input_group_a(grp_a),
         .i_single_input(single), .i_input_group_c(grp_c), .i_bidir_port_a_pin(pin_wire),
         .o_bidir_port_a_pin(), .o_bidir_port_a_pin_oe());
   end
   task automatic rd_chk(input logic [9:0] a, input logic [3:0] e);
      logic [3:0] r;
      i_cpu_model.access(1'b0, a, 4'h0, r);
      `CHK(r, e)
   endtask
   task automatic t_reset();
      logic [9:0] ra [16] = '{10'h2d0, 10'h2e0, 10'h2e1, 10'h2e2, 10'h2e4, 10'h2e5,
         10'h2e6, 10'h2e8, 10'h2e9, 10'h2ea, 10'h2eb, 10'h2ec, 10'h2ee, 10'h2ef, 10'h2f2, 10'h2f8};
      for (int i = 0; i < 16; i++) begin
         rd_chk(ra[i], i == 0 ? 4'h1 : i == 14 ? 4'hc : 4'h0);
      end
      `CHK(ctrl.display_blank, 1'b1)
      `CHK({pin_out, pin_oe, irq}, 12'h0)
      $display("t_reset done");
   endtask
   task automatic t_write();
      logic [17:0] wt [15] = '{{10'h2f0, 8'haa}, {10'h2f1, 8'h55}, {10'h2e0, 8'hf0},
         {10'h2e5, 8'hff}, {10'h2e6, 8'hfb}, {10'h2ec, 8'hfd}, {10'h2ee, 8'hf5},
         {10'h2f2, 8'h66}, {10'h2f6, 8'hfe}, {10'h2f7, 8'hfd}, {10'h2d0, 8'h00},
         {10'h2e7, 8'hf6}, {10'h2e8, 8'h77}, {10'h2f5, 8'hff}, {10'h2ef, 8'h80}};
      for (int i = 0; i < 15; i++) begin
         i_cpu_model.access(1'b1, wt[i][17:8], wt[i][7:4], q);
         rd_chk(wt[i][17:8], wt[i][3:0]);
      end
      `CHK(ctrl.stopwatch_run, 1'b1)
      `CHK(pin_oe, 4'hf)
      `CHK(ctrl.display_blank, 1'b0)
      $display("t_write done");
   endtask
   task automatic t_flags();
      logic [13:0] ft [6] = '{{10'h2e9, 4'h7}, {10'h2ea, 4'hf}, {10'h2f3, 4'h3},
         {10'h2e9, 4'h0}, {10'h2ea, 4'h0}, {10'h2f3, 4'h0}};
      ev = '1;
      @(posedge i_clk) #1;
      ev = '0;
      @(posedge i_clk) #1;
      `CHK(irq, 4'h7)
      for (int i = 0; i < 6; i++) begin
         rd_chk(ft[i][13:4], ft[i][3:0]);
      end
      `CHK(irq, 4'h0)
      $display("t_flags done");
   endtask
   task automatic t_pins();
      logic [13:0] pt [17] = '{{10'h2e3, 4'h9}, {10'h2f4, 4'h5}, {10'h2e7, 4'h7},
         {10'h2f8, 4'ha}, {10'h2f9, 4'h5}, {10'h2fa, 4'hc}, {10'h2fb, 4'h3}, {10'h2ed, 4'h3},
         {10'h2e0, 4'h6}, {10'h2e1, 4'h7}, {10'h2e2, 4'h3}, {10'h2ef, 4'h5}, {10'h2e6, 4'hf},
         {10'h2ec, 4'hf}, {10'h2f7, 4'hf}, {10'h2f0, 4'h6}, {10'h2f1, 4'h9}};
      grp_a = 4'h9;
      grp_c = 4'h5;
      single = 1'b1;
      stat.event_count_zero = 8'h5a;
      stat.event_count_one = 8'h3c;
      stat.clock_timer_stage = 4'h6;
      stat.stopwatch_hundredths_digit = 4'h7;
      stat.stopwatch_tenths_digit = 4'h3;
      stat.watchdog_stage = 3'h5;
      stat.sub_lowbatt_result = 1'b1;
      stat.comparator_result = 1'b1;
      stat.serial_run_status = 1'b1;
      stat.serial_shift_in = 8'h96;
      stat.serial_shift_load = 1'b1;
      i_cpu_model.access(1'b1, 10'h2ed, 4'h3, q);
      stat.serial_shift_load = 1'b0;
      repeat (8) @(posedge i_clk);
      for (int i = 0; i < 17; i++) begin
         rd_chk(pt[i][13:4], pt[i][3:0]);
      end
      // port back to input: the far side's level must show through
      i_cpu_model.access(1'b1, 10'h2ee, 4'h0, q);
      repeat (8) @(posedge i_clk);
      rd_chk(10'h2ed, 4'h6);
      `CHK({pin_oe, pin_out, ctrl.stopwatch_run}, {4'h0, 4'h3, 1'b0})
      $display("t_pins done");
   endtask
   task automatic t_disp();
      i_cpu_model.access(1'b1, 10'h045, 4'h9, q);
      `CHK({disp_wr, disp_idx, disp_data}, {1'b1, 6'h05, 4'h9})
      rd_chk(10'h045, 4'h9);
      g_page2.i_cpu_model.access(1'b1, 10'h245, 4'h7, q);
      `CHK({g_page2.disp_wr, g_page2.disp_idx}, {1'b1, 6'h05})
      g_page2.i_cpu_model.access(1'b0, 10'h245, 4'h0, q);
      `CHK(q, 4'h0)
      $display("t_disp done");
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      stat = '0;
      ev = '0;
      grp_a = 4'h0;
      grp_c = 4'h0;
      single = 1'b0;
      repeat (6) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      t_reset();
      t_write();
      t_flags();
      t_pins();
      t_disp();
      close_out();
   end
   initial begin
      #20000;
      n_fail++;
      close_out();
   end
endmodule
